// [core/ptx_cfg.svh]
// address map, field positions, widths, constants and counts of the tx stamp block
`ifndef PTX_CFG_SVH
`define PTX_CFG_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PTX_OFS_MOD2     9'h168
`define PTX_OFS_EGR_SEC  9'h16c
`define PTX_OFS_EGR_NS   9'h170
`define PTX_OFS_HEADER   9'h174
`define PTX_OFS_DREQ_SEC 9'h178
`define PTX_OFS_DREQ_NS  9'h17c
`define PTX_OFS_SELECT   9'h1c0
`define PTX_OFS_COUNT    9'h1c4
`define PTX_OFS_INSCTL   9'h1c8
`define PTX_OFS_INT_STS  9'h1cc
`define PTX_OFS_INT_CLR  9'h1d0
`define PTX_OFS_INT_EN   9'h1d4
// ----------------------------------------------------------------
// fields and constants
// ----------------------------------------------------------------
`define PTX_BANK_PORT    3'h2
`define PTX_BANK_W       3
`define PTX_PORT_W       2
`define PTX_PORT_LSB     8
`define PTX_CLR_BIT      0
`define PTX_SYNC_BIT     28
`define PTX_TURN_BIT     29
`define PTX_NS_W         30
`define PTX_DSEC_W       4
`define PTX_CRC_W        12
`define PTX_CRC_POLY     12'h80f
`define PTX_CRC_INIT     12'hfff
`define PTX_MSG_SYNC     4'h0
`define PTX_MSG_DREQ     4'h1
`define PTX_MSG_PDRESP   4'h3
`define PTX_INT_CAPTURE  0
`define PTX_INT_DROP     1
`define PTX_INT_W        2
`define PTX_DEPTH        4
`define PTX_CNT_W        3
`endif

// [core/ptx_pkg.sv]
// types shared by the tx stamp block
package ptx_pkg;
	// one egress capture as reported by a port transmit path
	typedef struct packed
	{
		logic [31:0] sec;
		logic [29:0] ns;
		logic [3:0]  kind;
		logic [15:0] seq;
		logic [79:0] srcIdentity;
	} ptx_capture_t;

	// one buffered entry
	typedef struct packed
	{
		logic [31:0] sec;
		logic [29:0] ns;
		logic [11:0] crc;
		logic [3:0]  kind;
		logic [15:0] seq;
	} ptx_entry_t;

	// per-frame modification request back to the transmit path
	typedef struct packed
	{
		logic syncInsert;
		logic turnInsert;
		logic clearChecksum;
	} ptx_modify_t;

	typedef enum logic [2:0]
	{
		PTX_IDLE = 3'b001,
		PTX_SYNC = 3'b010,
		PTX_TURN = 3'b100
	} ptx_mod_state_t;
endpackage

// [core/ptx_tx_timestamp_capture.sv]
// per-port transmit timestamp capture, delay request store and frame edits
`include "ptx_cfg.svh"

module ptx_tx_timestamp_capture #(
	parameter int NPORT = 3,
	parameter int DEPTH = `PTX_DEPTH
)(
	input  wire logic                                clk,
	input  wire logic                                rst_b,
	input  wire logic [8:0]                          regAddr,
	input  wire logic [31:0]                         regWrData,
	input  wire logic                                regWr,
	input  wire logic                                regRd,
	output logic      [31:0]                         regRdData,
	input  wire logic [NPORT-1:0]                    capValid,
	input  wire ptx_pkg::ptx_capture_t [NPORT-1:0]   capData,
	input  wire logic [NPORT-1:0]                    frameStart,
	input  wire logic [NPORT*4-1:0]                  frameKind,
	output ptx_pkg::ptx_modify_t [NPORT-1:0]         frameModify,
	input  wire logic [NPORT-1:0]                    respReq,
	output logic      [NPORT-1:0]                    respValid,
	output logic      [NPORT*34-1:0]                 respTime,
	input  wire logic                                unitEnable,
	output logic                                     irq
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [11:0] crc12(input logic [79:0] d);
		logic [11:0] c;
		c = `PTX_CRC_INIT;
		for (int i = 79; i >= 0; i--)
		begin
			if (c[11] ^ d[i])
				c = {c[10:0], 1'b0} ^ `PTX_CRC_POLY;
			else
				c = {c[10:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic isReg(input logic [8:0] a, input logic [8:0] o);
		return a == o;
	endfunction

	localparam int PW = $clog2(NPORT > 1 ? NPORT : 2);
	localparam int AW = $clog2(DEPTH);
	// one stored delay request time: seconds beside nanoseconds
	localparam int TW = `PTX_DSEC_W + `PTX_NS_W;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [`PTX_BANK_W-1:0] bankSel_r;
	logic [`PTX_PORT_W-1:0] portSel_r;
	logic [NPORT-1:0]       clrChk_r;
	logic [NPORT-1:0]       syncIns_r;
	logic [NPORT-1:0]       turnIns_r;
	logic [`PTX_INT_W*NPORT-1:0] intSts_r;
	logic [`PTX_INT_W*NPORT-1:0] intEn_r;
	logic                   portBank;
	logic                   portOk;
	logic [PW-1:0]          selPort;

	assign portBank = bankSel_r == `PTX_BANK_PORT;
	assign portOk   = portBank && (32'(portSel_r) < NPORT);
	assign selPort  = PW'(portSel_r);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bankSel_r <= '0;
			portSel_r <= '0;
		end
		else if (regWr && isReg(regAddr, `PTX_OFS_SELECT))
		begin
			bankSel_r <= regWrData[`PTX_BANK_W-1:0];
			portSel_r <= regWrData[`PTX_PORT_LSB +: `PTX_PORT_W];
		end
	end

	// the host is trusted not to touch this while the unit runs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			clrChk_r <= '0;
		else if (regWr && portOk && isReg(regAddr, `PTX_OFS_MOD2))
			clrChk_r[selPort] <= regWrData[`PTX_CLR_BIT];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			syncIns_r <= '0;
			turnIns_r <= '0;
		end
		else if (regWr && portOk && isReg(regAddr, `PTX_OFS_INSCTL))
		begin
			syncIns_r[selPort] <= regWrData[`PTX_SYNC_BIT];
			turnIns_r[selPort] <= regWrData[`PTX_TURN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// capture buffers
	// ----------------------------------------------------------------
	ptx_pkg::ptx_entry_t   buf_r [NPORT][DEPTH];
	logic [AW-1:0]         wrPtr_r [NPORT];
	logic [AW-1:0]         rdPtr_r [NPORT];
	logic [`PTX_CNT_W-1:0] cnt_r [NPORT];
	logic [`PTX_DSEC_W-1:0] dreqSec_r [NPORT];
	logic [`PTX_NS_W-1:0]  dreqNs_r [NPORT];
	logic [NPORT-1:0]      push;
	logic [NPORT-1:0]      drop;
	logic [NPORT-1:0]      pop;
	ptx_pkg::ptx_entry_t   head;

	assign head = buf_r[selPort][rdPtr_r[selPort]];

	for (genvar p = 0; p < NPORT; p++)
	begin : g_port
		// a capture that meets a full buffer is lost even when a read
		// frees an entry in the same cycle; unread entries are never lost
		logic full;
		assign full    = 32'(cnt_r[p]) == DEPTH;
		assign push[p] = capValid[p] && !full;
		assign drop[p] = capValid[p] && full;
		// the header word is the last of an entry, so reading it frees it
		assign pop[p]  = regRd && portOk && selPort == PW'(p)
			&& isReg(regAddr, `PTX_OFS_HEADER) && cnt_r[p] != '0;

		always_ff @(posedge clk)
		begin
			if (push[p])
			begin
				buf_r[p][wrPtr_r[p]].sec  <= capData[p].sec;
				buf_r[p][wrPtr_r[p]].ns   <= capData[p].ns;
				buf_r[p][wrPtr_r[p]].crc  <= crc12(capData[p].srcIdentity);
				buf_r[p][wrPtr_r[p]].kind <= capData[p].kind;
				buf_r[p][wrPtr_r[p]].seq  <= capData[p].seq;
			end
		end

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				wrPtr_r[p] <= '0;
				rdPtr_r[p] <= '0;
				cnt_r[p]   <= '0;
			end
			else
			begin
				if (push[p])
					wrPtr_r[p] <= AW'(32'(wrPtr_r[p]) + 1);
				if (pop[p])
					rdPtr_r[p] <= AW'(32'(rdPtr_r[p]) + 1);
				if (push[p] && !pop[p])
					cnt_r[p] <= cnt_r[p] + 3'h1;
				else if (pop[p] && !push[p])
					cnt_r[p] <= cnt_r[p] - 3'h1;
			end
		end

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				dreqSec_r[p] <= '0;
				dreqNs_r[p]  <= '0;
			end
			else if (capValid[p] && capData[p].kind == `PTX_MSG_DREQ)
			begin
				dreqSec_r[p] <= capData[p].sec[`PTX_DSEC_W-1:0];
				dreqNs_r[p]  <= capData[p].ns;
			end
		end

		// delay response insertion reads the stored time
		// the answer copies the stored time every cycle, so a request in
		// the cycle of a delay request capture still sees the older time
		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				respValid[p]           <= 1'b0;
				respTime[p*TW +: TW]   <= '0;
			end
			else
			begin
				respValid[p]           <= respReq[p];
				respTime[p*TW +: TW]   <= {dreqSec_r[p], dreqNs_r[p]};
			end
		end

		// ------------------------------------------------------------
		// in-flight modification decision per frame
		// ------------------------------------------------------------
		ptx_pkg::ptx_mod_state_t st_r;
		logic [3:0] kind;
		assign kind = frameKind[p*4 +: 4];

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
				st_r <= ptx_pkg::PTX_IDLE;
			else if (frameStart[p] && unitEnable)
			begin
				if (syncIns_r[p] && kind == `PTX_MSG_SYNC)
					st_r <= ptx_pkg::PTX_SYNC;
				else if (turnIns_r[p] && kind == `PTX_MSG_PDRESP)
					st_r <= ptx_pkg::PTX_TURN;
				else
					st_r <= ptx_pkg::PTX_IDLE;
			end
			else if (frameStart[p])
				st_r <= ptx_pkg::PTX_IDLE;
		end

		always_comb
		begin
			frameModify[p] = '0;
			case (st_r)
				ptx_pkg::PTX_SYNC:
				begin
					frameModify[p].syncInsert    = 1'b1;
					frameModify[p].clearChecksum = clrChk_r[p];
				end
				ptx_pkg::PTX_TURN:
				begin
					frameModify[p].turnInsert    = 1'b1;
					frameModify[p].clearChecksum = clrChk_r[p];
				end
				default:
					frameModify[p] = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupts: capture stored, capture dropped
	// ----------------------------------------------------------------
	// status is not banked: one clear write serves every port
	logic [`PTX_INT_W*NPORT-1:0] intSet;
	logic [`PTX_INT_W*NPORT-1:0] intClr;

	always_comb
	begin
		intSet = '0;
		for (int p = 0; p < NPORT; p++)
		begin
			intSet[p*`PTX_INT_W + `PTX_INT_CAPTURE] = push[p];
			intSet[p*`PTX_INT_W + `PTX_INT_DROP]    = drop[p];
		end
	end

	assign intClr = (regWr && isReg(regAddr, `PTX_OFS_INT_CLR))
		? regWrData[`PTX_INT_W*NPORT-1:0] : '0;

	// a set in the same cycle as its clear wins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			intSts_r <= '0;
		else
			intSts_r <= (intSts_r & ~intClr) | intSet;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			intEn_r <= '0;
		else if (regWr && isReg(regAddr, `PTX_OFS_INT_EN))
			intEn_r <= regWrData[`PTX_INT_W*NPORT-1:0];
	end

	assign irq = |(intSts_r & intEn_r);

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	logic [31:0] rdMux;

	always_comb
	begin
		rdMux = '0;
		if (portOk)
		begin
			case (regAddr)
				`PTX_OFS_MOD2:     rdMux = {31'h0, clrChk_r[selPort]};
				`PTX_OFS_EGR_SEC:  rdMux = head.sec;
				`PTX_OFS_EGR_NS:   rdMux = {2'h0, head.ns};
				`PTX_OFS_HEADER:   rdMux = {head.crc, head.kind, head.seq};
				`PTX_OFS_DREQ_SEC: rdMux = {28'h0, dreqSec_r[selPort]};
				`PTX_OFS_DREQ_NS:  rdMux = {2'h0, dreqNs_r[selPort]};
				`PTX_OFS_COUNT:    rdMux = {29'h0, cnt_r[selPort]};
				`PTX_OFS_INSCTL:   rdMux = {2'h0, turnIns_r[selPort],
					syncIns_r[selPort], 28'h0};
				default:           rdMux = '0;
			endcase
		end
		case (regAddr)
			`PTX_OFS_SELECT:  rdMux = {22'h0, portSel_r, 5'h0, bankSel_r};
			`PTX_OFS_INT_STS: rdMux = 32'(intSts_r);
			`PTX_OFS_INT_EN:  rdMux = 32'(intEn_r);
			default:          rdMux = rdMux;
		endcase
	end

	// an empty buffer reads as zero so stale words are never shown
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			regRdData <= '0;
		else if (regRd)
			regRdData <= (portOk && cnt_r[selPort] == '0
				&& (isReg(regAddr, `PTX_OFS_EGR_SEC)
				|| isReg(regAddr, `PTX_OFS_EGR_NS)
				|| isReg(regAddr, `PTX_OFS_HEADER))) ? '0 : rdMux;
		else
			regRdData <= '0;
	end
endmodule // ptx_tx_timestamp_capture

// [sim/ptx_tx_timestamp_capture_sva.sv]
// port-level checker of the tx stamp block
module ptx_tx_timestamp_capture_sva #(
	parameter int NPORT = 3
)(
	input wire logic                             clk,
	input wire logic                             rst_b,
	input wire logic                             regRd,
	input wire logic [31:0]                      regRdData,
	input wire logic [NPORT-1:0]                 capValid,
	input wire ptx_pkg::ptx_capture_t [NPORT-1:0] capData,
	input wire logic [NPORT-1:0]                 frameStart,
	input wire logic [NPORT*4-1:0]               frameKind,
	input wire ptx_pkg::ptx_modify_t [NPORT-1:0] frameModify,
	input wire logic [NPORT-1:0]                 respReq,
	input wire logic [NPORT-1:0]                 respValid,
	input wire logic [NPORT*34-1:0]              respTime,
	input wire logic                             unitEnable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------------------------------
	// port 0 stands for all ports
	// ----------------------------------------------------------------
	a_rd_quiet: assert property (regRdData != 32'h0 |-> $past(regRd))
		else $error("read data outside its slot");
	a_resp_next: assert property (respValid == $past(respReq))
		else $error("delay time answer not one cycle late");
	// stored time may lag its capture by up to two registers
	a_dreq_keep: assert property ($changed(respTime[33:0]) |->
		($past(capValid[0]) && $past(capData[0].kind) == 4'h1) ||
		($past(capValid[0], 2) && $past(capData[0].kind, 2) == 4'h1))
		else $error("delay time moved without a capture");
	a_mod_hold: assert property (!$past(frameStart[0])
		|-> $stable(frameModify[0]))
		else $error("frame edit changed mid frame");
	a_sync_kind: assert property (frameStart[0]
		&& frameKind[3:0] != 4'h0 |=> !frameModify[0].syncInsert)
		else $error("time insert on a non-sync frame");
	a_turn_kind: assert property (frameStart[0]
		&& frameKind[3:0] != 4'h3 |=> !frameModify[0].turnInsert)
		else $error("turnaround insert on wrong frame");
	a_clr_only: assert property (frameModify[0].clearChecksum
		|-> frameModify[0].syncInsert || frameModify[0].turnInsert)
		else $error("checksum cleared without an insert");
	a_off_quiet: assert property (frameStart[0] && !unitEnable
		|=> frameModify[0] == 3'b000)
		else $error("frame edit while unit disabled");
	c_sync: cover property (frameStart[0] ##1 frameModify[0].syncInsert);
	c_turn: cover property (frameStart[0] ##1 frameModify[0].turnInsert);
	c_dreq: cover property (capValid[0] && capData[0].kind == 4'h1);
endmodule // ptx_tx_timestamp_capture_sva

bind ptx_tx_timestamp_capture ptx_tx_timestamp_capture_sva #(.NPORT(NPORT))
	chk (.clk, .rst_b, .regRd, .regRdData, .capValid, .capData, .frameStart,
	.frameKind, .frameModify, .respReq, .respValid, .respTime, .unitEnable);

// [sim/ptx_port_model.sv]
// port transmit path model: captures, frame starts, delay time requests
module ptx_port_model (
	input  wire logic             clk,
	output ptx_pkg::ptx_capture_t capData,
	output logic                  capValid,
	output logic                  frameStart,
	output logic [3:0]            frameKind,
	output logic                  respReq
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle lines carry inverted data so stale values never pass
	initial
	begin
		capValid = 1'b0;
		frameStart = 1'b0;
		respReq = 1'b0;
		frameKind = 4'ha;
		capData = '1;
	end
	task automatic capture(input ptx_pkg::ptx_capture_t c);
		@(posedge clk);
		capValid <= 1'b1;
		capData <= c;
		@(posedge clk);
		capValid <= 1'b0;
		capData <= ~c;
	endtask
	task automatic frame(input logic [3:0] k);
		@(posedge clk);
		frameStart <= 1'b1;
		frameKind <= k;
		@(posedge clk);
		frameStart <= 1'b0;
		frameKind <= ~k;
	endtask
	task automatic ask;
		@(posedge clk);
		respReq <= 1'b1;
		@(posedge clk);
		respReq <= 1'b0;
	endtask
endmodule // ptx_port_model

// [sim/testbench.sv]
// self-checking bench of the tx stamp block
`include "ptx_cfg.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic [8:0]            regAddr = 9'h0;
	logic [31:0]           regWrData = 32'h0;
	logic                  regWr = 1'b0;
	logic                  regRd = 1'b0;
	logic                  unitEnable = 1'b0;
	logic                  rdLate = 1'b0;
	logic [31:0]           regRdData;
	logic                  capValid, frameStart, respReq, respValid, irq;
	logic [3:0]            frameKind;
	logic [33:0]           respTime;
	ptx_pkg::ptx_capture_t capData;
	ptx_pkg::ptx_modify_t  frameModify;
	ptx_pkg::ptx_capture_t cap [5];
	logic [31:0]           expQ [$];
	string                 nameQ [$];
	int                    nErrors = 0;
	int                    totalChecks = 0;
	always #2.5 clk = ~clk;
	ptx_tx_timestamp_capture #(.NPORT(1)) uut (.clk, .rst_b, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .capValid, .capData,
		.frameStart, .frameKind, .frameModify, .respReq, .respValid,
		.respTime, .unitEnable, .irq);
	ptx_port_model mdl (.clk, .capData, .capValid, .frameStart,
		.frameKind, .respReq);
	// ----------------------------------------------------------------
	// bus tasks and result comparison
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		totalChecks++;
		if (s !== e)
		begin
			nErrors++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		expQ.push_back(e);
		nameQ.push_back($sformatf("reg %h", a));
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
	endtask
	always @(posedge clk)
		rdLate <= regRd;
	always @(negedge clk)
		if (rdLate)
			chk(nameQ.pop_front(), regRdData, expQ.pop_front());
	function automatic logic [11:0] crc12(input logic [79:0] d);
		logic [11:0] c;
		c = `PTX_CRC_INIT;
		for (int i = 79; i >= 0; i--)
			c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? `PTX_CRC_POLY : 12'h0);
		return c;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		nErrors++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h4a82a134));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wr(`PTX_OFS_SELECT, 32'h2);
		for (int i = 0; i < 6; i++)
			rd(9'h168 + 9'(4 * i), 32'h0);
		rd(`PTX_OFS_COUNT, 32'h0);
		wr(9'h1fc, 32'hffffffff);
		rd(9'h1fc, 32'h0);
		$display("test reset values done");
		// last capture is a delay request arriving at a full buffer
		for (int i = 0; i < 5; i++)
		begin
			cap[i] = 162'({$urandom, $urandom, $urandom, $urandom,
				$urandom, $urandom});
			cap[i].kind = (i == 4) ? 4'h1 : 4'h2 + 4'(i);
			mdl.capture(cap[i]);
		end
		rd(`PTX_OFS_COUNT, 32'h4);
		rd(`PTX_OFS_INT_STS, 32'h3);
		@(negedge clk);
		chk("irq masked", 32'(irq), 32'h0);
		wr(`PTX_OFS_INT_EN, 32'h3);
		@(negedge clk);
		chk("irq raised", 32'(irq), 32'h1);
		rd(`PTX_OFS_DREQ_SEC, {28'h0, cap[4].sec[3:0]});
		rd(`PTX_OFS_DREQ_NS, {2'b00, cap[4].ns});
		mdl.ask();
		#1;
		chk("resp valid", 32'(respValid), 32'h1);
		chk("resp sec", 32'(respTime[33:30]), 32'(cap[4].sec[3:0]));
		chk("resp ns", 32'(respTime[29:0]), 32'(cap[4].ns));
		wr(`PTX_OFS_SELECT, 32'h102);
		rd(`PTX_OFS_HEADER, 32'h0);
		wr(`PTX_OFS_SELECT, 32'h3);
		rd(`PTX_OFS_HEADER, 32'h0);
		wr(`PTX_OFS_SELECT, 32'h2);
		for (int i = 0; i < 4; i++)
		begin
			rd(`PTX_OFS_EGR_SEC, cap[i].sec);
			rd(`PTX_OFS_EGR_NS, {2'b00, cap[i].ns});
			rd(`PTX_OFS_HEADER, {crc12(cap[i].srcIdentity),
				cap[i].kind, cap[i].seq});
		end
		rd(`PTX_OFS_COUNT, 32'h0);
		wr(`PTX_OFS_INT_CLR, 32'h3);
		rd(`PTX_OFS_INT_STS, 32'h0);
		@(negedge clk);
		chk("irq cleared", 32'(irq), 32'h0);
		$display("test capture buffer done");
		// clear-checksum is set while the unit is still disabled
		wr(`PTX_OFS_MOD2, 32'hffffffff);
		rd(`PTX_OFS_MOD2, 32'h1);
		wr(`PTX_OFS_INSCTL, 32'h30000000);
		for (int e = 0; e < 2; e++)
		begin
			@(posedge clk);
			unitEnable <= e[0];
			for (int k = 0; k < 5; k++)
			begin
				mdl.frame(4'(k));
				@(negedge clk);
				chk("modify", 32'(frameModify),
					(k == 0) ? 32'(e * 5) : (k == 3) ? 32'(e * 3) : 32'h0);
			end
		end
		// with clear-checksum cleared the insert goes on but the checksum stays
		@(posedge clk);
		unitEnable <= 1'b0;
		wr(`PTX_OFS_MOD2, 32'h0);
		@(posedge clk);
		unitEnable <= 1'b1;
		mdl.frame(4'h0);
		@(negedge clk);
		chk("modify no clear", 32'(frameModify), 32'h4);
		$display("test frame edits done");
		tally_and_finish();
	end
endmodule // testbench
